/* inc/adc_flags_params.svh */
// Reset values of the converter status flags
`ifndef ADC_FLAGS_PARAMS_SVH
`define ADC_FLAGS_PARAMS_SVH

// Reset value of every flag and activity bit
`define ADC_FLAG_RST     1'b0
// Default channel count and result width
`define ADC_NUM_CHAN     8
`define ADC_DATA_WIDTH   10

`endif

/* inc/adc_flags_pkg.sv */
// Types shared by the converter status flag logic
package adc_flags_pkg;

  // Converter power and activity state, one-hot
  typedef enum logic [2:0] {
    PWR_IDLE       = 3'b001,
    PWR_CONVERTING = 3'b010,
    PWR_ASLEEP     = 3'b100
  } pwr_state_t;

endpackage

/* inc/chan_flags_if.sv */
// Carrier between the flag controller and one channel's flag slice
`timescale 1ns/1ns
interface chan_flags_if #(
  parameter int DW = 10
);
  logic          store;       // Result stored for this channel
  logic          clear_done;  // Done flag cleared by a read
  logic          clear_ovr;   // Overrun flag cleared by status read
  logic [DW-1:0] data;        // Converted result
  logic          done;        // Done flag
  logic          ovr;         // Channel overrun flag
  logic [DW-1:0] result;      // Channel result register

  modport ctrl (output store, clear_done, clear_ovr, data,
                input  done, ovr, result);
  modport slice (input  store, clear_done, clear_ovr, data,
                 output done, ovr, result);
endinterface

/* rtl/adc_channel_flags.sv */
// One channel's done flag, overrun flag and result register
`timescale 1ns/1ns
`include "adc_flags_params.svh"
module adc_channel_flags #(
  parameter int DW = 10
) (
  input  wire logic   clock,
  input  wire logic   rst,
  input  wire logic   clk_en,
  chan_flags_if.slice fl
);

  logic          done_q;    // Done flag
  logic          ovr_q;     // Overrun flag
  logic [DW-1:0] result_q;  // Stored result

  // ****************************************************
  // Flag and result storage
  // ****************************************************

  // Done: set wins over a coinciding read clear
  always_ff @(posedge clock) begin
    if (rst) begin
      done_q <= `ADC_FLAG_RST;
    end else if (clk_en) begin
      if (fl.store) begin
        done_q <= 1'b1;
      end else if (fl.clear_done) begin
        done_q <= 1'b0;
      end
    end
  end

  // Overrun: new result over an unread one; status read clears
  always_ff @(posedge clock) begin
    if (rst) begin
      ovr_q <= `ADC_FLAG_RST;
    end else if (clk_en) begin
      if (fl.store && done_q) begin
        ovr_q <= 1'b1;
      end else if (fl.clear_ovr) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // Result register follows every accepted conversion
  always_ff @(posedge clock) begin
    if (rst) begin
      result_q <= '0;
    end else if (clk_en && fl.store) begin
      result_q <= fl.data;
    end
  end

  assign fl.done   = done_q;
  assign fl.ovr    = ovr_q;
  assign fl.result = result_q;

endmodule

/* rtl/adc_conversion_status_flags.sv */
// Status flag controller of the analog-to-digital converter
`timescale 1ns/1ns
`include "adc_flags_params.svh"
// Contract
// - Only last-result read clears data ready
// - Coinciding last read sets ready only if stored
// - Other channel read never blocks data ready
// - Disable elsewhere still stores and raises ready
// - Status read still updates general overrun
// - Unread ready plus stored conversion sets general overrun
// - Disable elsewhere still raises both overruns
// - Channel or last read clears done
// - Status read clears overrun despite new done
// - Disabled channel's conversion never raises done
// - Channel read clears only its own done
// - Idle sleep request waits for conversion end
module adc_conversion_status_flags #(
  parameter int N_CHAN = `ADC_NUM_CHAN,
  parameter int DW     = `ADC_DATA_WIDTH,
  parameter int CW     = (N_CHAN > 1) ? $clog2(N_CHAN) : 1
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  input  wire logic [N_CHAN-1:0]    chan_enable_set,
  input  wire logic [N_CHAN-1:0]    chan_disable_set,
  input  wire logic                 conv_end,
  input  wire logic [CW-1:0]        conv_channel,
  input  wire logic [DW-1:0]        conv_data,
  input  wire logic                 read_last,
  input  wire logic                 read_chan,
  input  wire logic [CW-1:0]        read_chan_sel,
  input  wire logic                 read_status,
  input  wire logic                 sleep_select,
  input  wire logic                 start_conv,
  output logic [N_CHAN-1:0]         chan_enabled,
  output logic [N_CHAN-1:0]         chan_done,
  output logic [N_CHAN-1:0]         channel_overrun_flag,
  output logic [N_CHAN*DW-1:0]      channel_result_reg,
  output logic [DW-1:0]             last_result_reg,
  output logic [CW-1:0]             last_channel,
  output logic                      data_ready_flag,
  output logic                      general_overrun_flag,
  output logic                      converting,
  output logic                      asleep
);

  // ****************************************************
  // Elaboration checks
  // ****************************************************

  // Channel index must address every channel
  if (N_CHAN < 1 || (1 << CW) < N_CHAN || DW < 1) begin : g_bad
    $error("adc flags: channel count or widths unusable");
  end

  // ****************************************************
  // Declarations
  // ****************************************************

  logic [N_CHAN-1:0]    enabled_q;   // Channel enable bits
  logic [N_CHAN-1:0]    store_vec;   // Per-channel store strobe
  logic                 store_any;   // A result is stored this cycle
  logic                 ready_q;     // Data ready
  logic                 govr_q;      // General overrun
  logic [DW-1:0]        last_q;      // Last converted result
  logic [CW-1:0]        last_ch_q;   // Channel of last result
  logic                 conv_q;      // Conversion in progress
  logic                 sleep_q;     // Converter asleep
  adc_flags_pkg::pwr_state_t state_q;  // Activity state
  adc_flags_pkg::pwr_state_t state_d;  // Next activity state

  // ****************************************************
  // Channel enables
  // ****************************************************

  // Enable register; a disable wins over a coinciding enable
  always_ff @(posedge clock) begin
    if (rst) begin
      enabled_q <= '0;
    end else if (clk_en) begin
      enabled_q <= (enabled_q | chan_enable_set) & ~chan_disable_set;
    end
  end

  // ****************************************************
  // Store decision
  // ****************************************************

  // Store only for a channel enabled and not being disabled now;
  // disables of other channels have no bearing
  always_comb begin
    store_vec = '0;
    for (int i = 0; i < N_CHAN; i++) begin
      store_vec[i] = conv_end && (conv_channel == CW'(i))
                     && enabled_q[i] && !chan_disable_set[i];
    end
  end

  // Any store raises data ready, whatever reads coincide
  assign store_any = |store_vec;

  // ****************************************************
  // Channel slices
  // ****************************************************

  for (genvar i = 0; i < N_CHAN; i++) begin : g_chan
    chan_flags_if #(.DW(DW)) fl ();

    assign fl.store = store_vec[i];
    // Own read, or last-result read of the last channel
    assign fl.clear_done = (read_chan && read_chan_sel == CW'(i))
                           || (read_last && last_ch_q == CW'(i));
    assign fl.clear_ovr  = read_status;
    assign fl.data       = conv_data;

    adc_channel_flags #(.DW(DW)) u_slice (
      .clock  (clock),
      .rst    (rst),
      .clk_en (clk_en),
      .fl     (fl)
    );

    assign chan_done[i]                     = fl.done;
    assign channel_overrun_flag[i]          = fl.ovr;
    assign channel_result_reg[i*DW +: DW]   = fl.result;
  end

  // ****************************************************
  // Global flags
  // ****************************************************

  // Data ready: store wins; channel reads have no effect
  always_ff @(posedge clock) begin
    if (rst) begin
      ready_q <= `ADC_FLAG_RST;
    end else if (clk_en) begin
      if (store_any) begin
        ready_q <= 1'b1;
      end else if (read_last) begin
        ready_q <= 1'b0;
      end
    end
  end

  // General overrun: store over unread last result; status clears
  always_ff @(posedge clock) begin
    if (rst) begin
      govr_q <= `ADC_FLAG_RST;
    end else if (clk_en) begin
      if (store_any && ready_q && !read_last) begin
        govr_q <= 1'b1;
      end else if (read_status) begin
        govr_q <= 1'b0;
      end
    end
  end

  // Last result and its channel
  always_ff @(posedge clock) begin
    if (rst) begin
      last_q    <= '0;
      last_ch_q <= '0;
    end else if (clk_en && store_any) begin
      last_q    <= conv_data;
      last_ch_q <= conv_channel;
    end
  end

  // ****************************************************
  // Activity and sleep
  // ****************************************************

  // Sleep is entered only at a conversion end, so an idle
  // request waits; software starts one conversion to get there
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      adc_flags_pkg::PWR_IDLE: begin
        if (start_conv) begin
          state_d = adc_flags_pkg::PWR_CONVERTING;
        end
      end
      adc_flags_pkg::PWR_CONVERTING: begin
        if (conv_end) begin
          state_d = sleep_select ? adc_flags_pkg::PWR_ASLEEP
                                 : adc_flags_pkg::PWR_IDLE;
        end
      end
      adc_flags_pkg::PWR_ASLEEP: begin
        if (start_conv) begin
          state_d = adc_flags_pkg::PWR_CONVERTING;
        end else if (!sleep_select) begin
          state_d = adc_flags_pkg::PWR_IDLE;
        end
      end
      default: begin
        state_d = adc_flags_pkg::PWR_IDLE; // Illegal code recovers
      end
    endcase
  end

  // State and its registered decodes
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= adc_flags_pkg::PWR_IDLE;
      conv_q  <= `ADC_FLAG_RST;
      sleep_q <= `ADC_FLAG_RST;
    end else if (clk_en) begin
      state_q <= state_d;
      conv_q  <= (state_d == adc_flags_pkg::PWR_CONVERTING);
      sleep_q <= (state_d == adc_flags_pkg::PWR_ASLEEP);
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************

  assign chan_enabled         = enabled_q;
  assign last_result_reg      = last_q;
  assign last_channel         = last_ch_q;
  assign data_ready_flag      = ready_q;
  assign general_overrun_flag = govr_q;
  assign converting           = conv_q;
  assign asleep               = sleep_q;

endmodule

/* tb/adc_flags_props.sv */
// Checker of the converter status flag relations
`timescale 1ns/1ns
module adc_flags_props #(
  parameter int N_CHAN = 8,
  parameter int DW     = 10,
  parameter int CW     = 3
) (
  input logic              clock,
  input logic              rst,
  input logic              clk_en,
  input logic [N_CHAN-1:0] chan_enabled,
  input logic [N_CHAN-1:0] chan_disable_set,
  input logic [N_CHAN-1:0] chan_done,
  input logic [N_CHAN-1:0] channel_overrun_flag,
  input logic              conv_end,
  input logic [CW-1:0]     conv_channel,
  input logic [DW-1:0]     conv_data,
  input logic [DW-1:0]     last_result_reg,
  input logic              read_last,
  input logic              read_chan,
  input logic [CW-1:0]     read_chan_sel,
  input logic              read_status,
  input logic              sleep_select,
  input logic              data_ready_flag,
  input logic              general_overrun_flag,
  input logic              converting,
  input logic              asleep
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Store happens only for a channel still enabled this cycle
  wire st = conv_end & chan_enabled[conv_channel]
            & ~chan_disable_set[conv_channel];
  property p_store;
    clk_en && st |=> chan_done[$past(conv_channel)] && data_ready_flag
      && last_result_reg == $past(conv_data);
  endproperty
  a_store: assert property (p_store) else $error("store lost");
  property p_ready_hold;
    clk_en && data_ready_flag && !read_last |=> data_ready_flag;
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("ready lost");
  property p_ready_clr;
    clk_en && read_last && !st |=> !data_ready_flag;
  endproperty
  a_ready_clr: assert property (p_ready_clr)
    else $error("ready kept");
  property p_gov_set;
    clk_en && st && data_ready_flag && !read_last |=> general_overrun_flag;
  endproperty
  a_gov_set: assert property (p_gov_set)
    else $error("overrun missed");
  property p_gov_clr;
    clk_en && read_status && !(st && data_ready_flag && !read_last)
      |=> !general_overrun_flag;
  endproperty
  a_gov_clr: assert property (p_gov_clr) else $error("overrun kept");
  property p_ovr_clr;
    clk_en && read_status && !(st && chan_done[conv_channel])
      |=> channel_overrun_flag == '0;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr)
    else $error("chan ovr kept");
  property p_read_clr;
    clk_en && read_chan && !(st && conv_channel == read_chan_sel)
      |=> !chan_done[$past(read_chan_sel)];
  endproperty
  a_read_clr: assert property (p_read_clr) else $error("done kept");
  property p_refuse;
    clk_en && conv_end && !st && !chan_done[conv_channel]
      |=> !chan_done[$past(conv_channel)];
  endproperty
  a_refuse: assert property (p_refuse) else $error("done raised");
  property p_sleep;
    // A frozen cycle would hold the state, so only running ends count
    clk_en && converting && conv_end && sleep_select |-> ##[1:2] asleep;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep");
  c_ovr: cover property (st && chan_done[conv_channel]);
  c_stat: cover property (st && read_status);
  c_sleep: cover property ($rose(asleep));
endmodule

/* tb/adc_conversion_status_flags_bench.sv */
// Self-checking bench of the converter status flag logic
`timescale 1ns/1ns
module adc_conversion_status_flags_bench;
  logic        clock = 1'b0;                 // 250 MHz clock
  logic        rst = 1'b1;                   // Synchronous reset
  logic        clk_en = 1'b1;                // Run enable
  logic        ce = 1'b0, rl = 1'b0;         // End, last read
  logic        rc = 1'b0, rs = 1'b0;         // Channel and status read
  logic        slp = 1'b0, go = 1'b0;        // Sleep level, start pulse
  logic [7:0]  en = 8'h00, dis = 8'h00;      // Enable, disable pulses
  logic [2:0]  ch = 3'h0, sel = 3'h0;        // Channel selects
  logic [9:0]  d = 10'h000;                  // Conversion result
  wire  [7:0]  done, ovr, ena;
  wire  [79:0] res;
  wire  [9:0]  last;
  wire  [2:0]  lch;
  wire         rdy, gov, conv, slept;
  int          miscompares = 0, n_tests = 0, cycles = 0;
  adc_conversion_status_flags #(.N_CHAN(8), .DW(10)) DUT (
    .clock, .rst, .clk_en, .chan_enable_set(en), .chan_disable_set(dis),
    .conv_end(ce), .conv_channel(ch), .conv_data(d), .read_last(rl),
    .read_chan(rc), .read_chan_sel(sel), .read_status(rs),
    .sleep_select(slp), .start_conv(go), .chan_enabled(ena),
    .chan_done(done), .channel_overrun_flag(ovr), .channel_result_reg(res),
    .last_result_reg(last), .last_channel(lch), .data_ready_flag(rdy),
    .general_overrun_flag(gov), .converting(conv), .asleep(slept));
  // ****************
  // Clock and ceiling
  // ****************
  always #2 clock = ~clock;
  // Cuts a hang short, far above the ~50 cycles of the run
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares = miscompares + 1;
      end_of_test;
    end
  end
  task chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Flags: freeze, end, last read, channel read, status read
  task op(input logic [4:0] f, input logic [2:0] c, input logic [9:0] v,
          input logic [2:0] s, input logic [7:0] x);
    @(posedge clock);
    {clk_en, ce, rl, rc, rs} <= f ^ 5'h10;
    ch <= c;
    d <= v;
    sel <= s;
    dis <= x;
    @(posedge clock);
    {clk_en, ce, rl, rc, rs} <= 5'h10;
    dis <= 8'h00;
    #1;
  endtask
  // Compares done, channel overrun, ready and general overrun
  task st(input logic [7:0] ed, eo, input logic er, eg);
    chk("done", done, ed);
    chk("ovr", ovr, eo);
    chk("ready", rdy, er);
    chk("general_overrun_flag", gov, eg);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Channels 0..3 enabled, then event sequences
  initial begin
    repeat (5) @(posedge clock);
    #1;
    // Flag, enable and activity outputs must read zero while reset is held
    st(8'h00, 8'h00, 0, 0);
    chk("enabled", ena, 8'h00);
    chk("asleep", slept, 1'b0);
    chk("converting", conv, 1'b0);
    @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    en <= 8'h0f;
    @(posedge clock);
    en <= 8'h00;
    op(5'h08, 3'h2, 10'h155, 3'h0, 8'h00);
    st(8'h04, 8'h00, 1, 0);
    chk("result2", res[20+:10], 10'h155);
    chk("lastch", lch, 3'h2);
    op(5'h02, 3'h0, 10'h000, 3'h2, 8'h00);
    st(8'h00, 8'h00, 1, 0);
    op(5'h08, 3'h0, 10'h0aa, 3'h0, 8'h00);
    st(8'h01, 8'h00, 1, 1);
    op(5'h09, 3'h1, 10'h033, 3'h0, 8'h00);
    st(8'h03, 8'h00, 1, 1);
    op(5'h01, 3'h0, 10'h000, 3'h0, 8'h00);
    st(8'h03, 8'h00, 1, 0);
    op(5'h0d, 3'h3, 10'h0f0, 3'h0, 8'h00);
    st(8'h09, 8'h00, 1, 0);
    op(5'h0a, 3'h3, 10'h3cc, 3'h0, 8'h00);
    st(8'h08, 8'h08, 1, 1);
    op(5'h02, 3'h0, 10'h000, 3'h3, 8'h00);
    st(8'h00, 8'h08, 1, 1);
    op(5'h09, 3'h3, 10'h001, 3'h0, 8'h00);
    st(8'h08, 8'h00, 1, 1);
    op(5'h04, 3'h0, 10'h000, 3'h0, 8'h00);
    st(8'h00, 8'h00, 0, 1);
    op(5'h08, 3'h0, 10'h001, 3'h0, 8'h00);
    op(5'h0c, 3'h5, 10'h3ff, 3'h0, 8'h00);
    st(8'h00, 8'h00, 0, 1);
    chk("last", last, 10'h001);
    op(5'h09, 3'h2, 10'h100, 3'h0, 8'h00);
    st(8'h04, 8'h00, 1, 0);
    op(5'h08, 3'h2, 10'h2aa, 3'h0, 8'h02);
    st(8'h04, 8'h04, 1, 1);
    chk("last", last, 10'h2aa);
    chk("result2", res[20+:10], 10'h2aa);
    chk("lastch", lch, 3'h2);
    chk("enabled", ena, 8'h0d);
    op(5'h0a, 3'h1, 10'h077, 3'h0, 8'h00);
    st(8'h04, 8'h04, 1, 1);
    op(5'h14, 3'h0, 10'h000, 3'h0, 8'h00);
    st(8'h04, 8'h04, 1, 1);
    @(posedge clock);
    slp <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    chk("asleep", slept, 1'b0);
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    #1;
    chk("converting", conv, 1'b1);
    op(5'h08, 3'h0, 10'h011, 3'h0, 8'h00);
    @(posedge clock);
    #1;
    chk("asleep", slept, 1'b1);
    chk("converting", conv, 1'b0);
    end_of_test;
  end
endmodule

bind adc_conversion_status_flags adc_flags_props #(
  .N_CHAN(N_CHAN), .DW(DW), .CW(CW)) props (
  .clock, .rst, .clk_en, .chan_enabled, .chan_disable_set, .chan_done,
  .channel_overrun_flag, .conv_end, .conv_channel, .conv_data,
  .last_result_reg, .read_last, .read_chan, .read_chan_sel, .read_status,
  .sleep_select, .data_ready_flag, .general_overrun_flag, .converting,
  .asleep);
